/* File: src/codec_global_control_regs.sv */
// Global control and status register bank, addresses 0x0 to 0x4 of page 0.
// Assumes a byte register port from the control front end, one access per strobe.
//
// Operation
// - Eight-bit page select, resets to zero.
// - Writing one soft-resets every register.
// - Bits 5-4 choose reference quick-charge time.
// - Bit 3 chooses whether the reference is enabled on wake.
// - Bit 2 selects analog supply arrangement.
// - Bit 1 selects I/O supply mode.
// - Bit 0 awake; device starts asleep.
// - Status bit 7 flags analog supply forced.
// - Status bit 6 flags I/O supply forced.
// - Status bit 1 reports undervoltage shutdown.
// - Status bit 0 chooses wake after undervoltage.
// - Misc bit 6 ignores clock errors.
// - Misc bit 1 enables group address.
`timescale 1ns/1ps
module codec_global_control_regs #(
  parameter int QCHG_CYC0 = codec_regs_pkg::QCHG_CYC0,
  parameter int QCHG_CYC1 = codec_regs_pkg::QCHG_CYC1,
  parameter int QCHG_CYC2 = codec_regs_pkg::QCHG_CYC2,
  parameter int QCHG_CYC3 = codec_regs_pkg::QCHG_CYC3
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Register port
  input wire codec_regs_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Supply detector pins, asynchronous
  input wire codec_regs_pkg::supply_evt_s det_pins,
  // Power and addressing controls
  output codec_regs_pkg::power_ctl_s pwr_ctl,
  output logic digital_regulator_en,
  output logic reference_en,
  output logic shutdown
);

  // ****************************************
  // Elaboration checks
  // ****************************************
  initial begin
    if (QCHG_CYC0 < 1 || QCHG_CYC1 < 1 || QCHG_CYC2 < 1 || QCHG_CYC3 < 1)
      $error("codec_global_control_regs: quick-charge counts must be positive");
    if (QCHG_CYC3 >= 2 ** 24) $error("codec_global_control_regs: count too wide");
  end

  // ****************************************
  // Detector synchronisation
  // ****************************************
  codec_regs_pkg::supply_evt_s det;

  codec_pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en(clk_en),
    .pin_in(det_pins),
    .level_out(det)
  );

  function automatic logic [23:0] qchg_cycles(input logic [1:0] code);
    unique case (code)
      2'h0: qchg_cycles = 24'(QCHG_CYC0);
      2'h1: qchg_cycles = 24'(QCHG_CYC1);
      2'h2: qchg_cycles = 24'(QCHG_CYC2);
      2'h3: qchg_cycles = 24'(QCHG_CYC3);
    endcase
  endfunction

  function automatic logic hit(input codec_regs_pkg::reg_req_s r, input logic [7:0] a,
                               input logic [7:0] page);
    // Page select answers on any page
    hit = (r.addr == a) && ((a == codec_regs_pkg::ADDR_PAGE_SELECT) ||
          (page == codec_regs_pkg::PAGE_ZERO));
  endfunction

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0] page_r, page_nxt;
  logic [7:0] ref_r, ref_nxt;
  logic [7:0] misc_r, misc_nxt;
  logic uv_wake_r, uv_wake_nxt;
  logic uv_flag_r, uv_flag_nxt;
  logic soft_rst_r, soft_rst_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [7:0] status_byte;

  always_comb begin
    status_byte = codec_regs_pkg::RESET_BYTE;
    status_byte[codec_regs_pkg::ANALOG_FORCED_POS] = det.analog_high;
    status_byte[codec_regs_pkg::IO_FORCED_POS] = det.io_high;
    status_byte[codec_regs_pkg::UV_FLAG_POS] = uv_flag_r;
    status_byte[codec_regs_pkg::UV_WAKE_POS] = uv_wake_r;
  end

  always_comb begin
    page_nxt = page_r;
    ref_nxt = ref_r;
    misc_nxt = misc_r;
    uv_wake_nxt = uv_wake_r;
    uv_flag_nxt = uv_flag_r;
    soft_rst_nxt = 1'b0;
    rdata_nxt = rdata_r;
    rvalid_nxt = 1'b0;
    if (soft_rst_r) begin
      // One-cycle pulse restores every default, then reads back zero
      page_nxt = codec_regs_pkg::RESET_BYTE;
      ref_nxt = codec_regs_pkg::RESET_BYTE;
      misc_nxt = codec_regs_pkg::RESET_BYTE;
      uv_wake_nxt = 1'b0;
      uv_flag_nxt = 1'b0;
    end else begin
      if (req.wr) begin
        if (hit(req, codec_regs_pkg::ADDR_PAGE_SELECT, page_r)) page_nxt = req.wdata;
        if (hit(req, codec_regs_pkg::ADDR_SOFT_RESET, page_r))
          soft_rst_nxt = req.wdata[codec_regs_pkg::SOFT_RESET_POS];
        // Reserved bits stored as written; host keeps them at reset
        if (hit(req, codec_regs_pkg::ADDR_REF_POWER, page_r)) ref_nxt = req.wdata;
        if (hit(req, codec_regs_pkg::ADDR_SUPPLY_STATUS, page_r))
          uv_wake_nxt = req.wdata[codec_regs_pkg::UV_WAKE_POS];
        if (hit(req, codec_regs_pkg::ADDR_MISC_CONTROL, page_r)) misc_nxt = req.wdata;
      end
      if (req.rd) begin
        rvalid_nxt = 1'b1;
        rdata_nxt = codec_regs_pkg::RESET_BYTE;
        if (hit(req, codec_regs_pkg::ADDR_PAGE_SELECT, page_r)) rdata_nxt = page_r;
        if (hit(req, codec_regs_pkg::ADDR_SOFT_RESET, page_r))
          rdata_nxt = codec_regs_pkg::RESET_BYTE;
        if (hit(req, codec_regs_pkg::ADDR_REF_POWER, page_r)) rdata_nxt = ref_r;
        if (hit(req, codec_regs_pkg::ADDR_SUPPLY_STATUS, page_r)) rdata_nxt = status_byte;
        if (hit(req, codec_regs_pkg::ADDR_MISC_CONTROL, page_r)) rdata_nxt = misc_r;
      end
    end
    // Sticky; a same-cycle event beats the soft-reset clear
    if (det.undervoltage) uv_flag_nxt = 1'b1;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      page_r <= codec_regs_pkg::RESET_BYTE;
      ref_r <= codec_regs_pkg::RESET_BYTE;
      misc_r <= codec_regs_pkg::RESET_BYTE;
      uv_wake_r <= 1'b0;
      uv_flag_r <= 1'b0;
      soft_rst_r <= 1'b0;
      rdata_r <= codec_regs_pkg::RESET_BYTE;
      rvalid_r <= 1'b0;
    end else if (clk_en) begin
      page_r <= page_nxt;
      ref_r <= ref_nxt;
      misc_r <= misc_nxt;
      uv_wake_r <= uv_wake_nxt;
      uv_flag_r <= uv_flag_nxt;
      soft_rst_r <= soft_rst_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // ****************************************
  // Power sequencer
  // ****************************************
  codec_regs_pkg::pwr_state_e st_r, st_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  codec_regs_pkg::power_ctl_s ctl_r, ctl_nxt;
  logic digital_regulator_r, digital_regulator_nxt, vref_r, vref_nxt, shdn_r, shdn_nxt;
  logic awake_req, clk_fault;
  logic hold_r, hold_nxt;

  assign awake_req = ref_r[codec_regs_pkg::AWAKE_POS];
  assign clk_fault = det.clock_error && !misc_r[codec_regs_pkg::IGNORE_CLK_POS];

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    hold_nxt = hold_r;
    unique case (st_r)
      codec_regs_pkg::PWR_SLEEP: begin
        // After a held undervoltage exit the host must clear and set awake again
        if (awake_req && !hold_r) begin
          st_nxt = codec_regs_pkg::PWR_CHARGE;
          cnt_nxt = qchg_cycles(ref_r[codec_regs_pkg::FASTCHARGE_LO +: 2]);
        end
      end
      codec_regs_pkg::PWR_CHARGE: begin
        if (!awake_req) st_nxt = codec_regs_pkg::PWR_SLEEP;
        else if (cnt_r <= 24'h000001) st_nxt = codec_regs_pkg::PWR_RUN;
        else cnt_nxt = cnt_r - 24'h000001;
      end
      codec_regs_pkg::PWR_RUN: begin
        if (!awake_req) st_nxt = codec_regs_pkg::PWR_SLEEP;
      end
      codec_regs_pkg::PWR_SHUTDOWN: begin
        // Undervoltage gone: policy bit decides whether to wake again
        if (!det.undervoltage && !clk_fault) begin
          st_nxt = (uv_wake_r && awake_req) ? codec_regs_pkg::PWR_CHARGE
                                             : codec_regs_pkg::PWR_SLEEP;
          hold_nxt = !uv_wake_r;
        end
        cnt_nxt = qchg_cycles(ref_r[codec_regs_pkg::FASTCHARGE_LO +: 2]);
      end
    endcase
    if (det.undervoltage || (clk_fault && st_r != codec_regs_pkg::PWR_SLEEP))
      st_nxt = codec_regs_pkg::PWR_SHUTDOWN;
    if (!awake_req) hold_nxt = 1'b0;
    if (soft_rst_r) begin
      st_nxt = codec_regs_pkg::PWR_SLEEP;
      hold_nxt = 1'b0;
    end
  end

  always_comb begin
    ctl_nxt.fastcharge_time = ref_r[codec_regs_pkg::FASTCHARGE_LO +: 2];
    ctl_nxt.wake_reference = ref_r[codec_regs_pkg::WAKE_REF_POS];
    // Detected high supply overrides the configured mode
    ctl_nxt.analog_supply_select = ref_r[codec_regs_pkg::ANALOG_SEL_POS] &&
                                   !det.analog_high;
    ctl_nxt.io_supply_select = ref_r[codec_regs_pkg::IO_SEL_POS] && !det.io_high;
    ctl_nxt.awake = (st_nxt == codec_regs_pkg::PWR_CHARGE) ||
                    (st_nxt == codec_regs_pkg::PWR_RUN);
    ctl_nxt.reference_charging = (st_nxt == codec_regs_pkg::PWR_CHARGE);
    ctl_nxt.ignore_clock_error = misc_r[codec_regs_pkg::IGNORE_CLK_POS];
    ctl_nxt.group_address_enable = misc_r[codec_regs_pkg::GROUP_ADDR_POS];
    digital_regulator_nxt = ctl_nxt.awake;
    vref_nxt = ctl_nxt.awake && ctl_nxt.wake_reference;
    shdn_nxt = (st_nxt == codec_regs_pkg::PWR_SHUTDOWN);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= codec_regs_pkg::PWR_SLEEP;
      hold_r <= 1'b0;
      cnt_r <= '0;
      ctl_r <= '0;
      digital_regulator_r <= 1'b0;
      vref_r <= 1'b0;
      shdn_r <= 1'b0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      hold_r <= hold_nxt;
      cnt_r <= cnt_nxt;
      ctl_r <= ctl_nxt;
      digital_regulator_r <= digital_regulator_nxt;
      vref_r <= vref_nxt;
      shdn_r <= shdn_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
  assign pwr_ctl = ctl_r;
  assign digital_regulator_en = digital_regulator_r;
  assign reference_en = vref_r;
  assign shutdown = shdn_r;

endmodule

/* File: src/codec_regs_pkg.sv */
// Constants and carriers for the global control register bank.
// Assumes an 8-bit byte register port from the control serial front end.
package codec_regs_pkg;

  // ****************************************
  // Register addresses and resets
  // ****************************************
  localparam logic [7:0] ADDR_PAGE_SELECT = 8'h00;
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h01;
  localparam logic [7:0] ADDR_REF_POWER = 8'h02;
  localparam logic [7:0] ADDR_SUPPLY_STATUS = 8'h03;
  localparam logic [7:0] ADDR_MISC_CONTROL = 8'h04;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] PAGE_ZERO = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int SOFT_RESET_POS = 0;
  localparam int FASTCHARGE_LO = 4;
  localparam int WAKE_REF_POS = 3;
  localparam int ANALOG_SEL_POS = 2;
  localparam int IO_SEL_POS = 1;
  localparam int AWAKE_POS = 0;
  localparam int ANALOG_FORCED_POS = 7;
  localparam int IO_FORCED_POS = 6;
  localparam int UV_FLAG_POS = 1;
  localparam int UV_WAKE_POS = 0;
  localparam int IGNORE_CLK_POS = 6;
  localparam int GROUP_ADDR_POS = 1;
  // Writable masks: reserved bits of ref/misc are R/W and kept
  localparam logic [7:0] SUPPLY_WR_MASK = 8'h01;

  // ****************************************
  // Quick-charge timing
  // ****************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int QCHG_US0 = 3500;
  localparam int QCHG_US1 = 10000;
  localparam int QCHG_US2 = 50000;
  localparam int QCHG_US3 = 100000;
  localparam int QCHG_CYC0 = QCHG_US0 * (CLK_HZ / 1_000_000);
  localparam int QCHG_CYC1 = QCHG_US1 * (CLK_HZ / 1_000_000);
  localparam int QCHG_CYC2 = QCHG_US2 * (CLK_HZ / 1_000_000);
  localparam int QCHG_CYC3 = QCHG_US3 * (CLK_HZ / 1_000_000);

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic analog_high;
    logic io_high;
    logic undervoltage;
    logic clock_error;
  } supply_evt_s;

  typedef struct packed {
    logic [1:0] fastcharge_time;
    logic wake_reference;
    logic analog_supply_select;
    logic io_supply_select;
    logic awake;
    logic reference_charging;
    logic ignore_clock_error;
    logic group_address_enable;
  } power_ctl_s;

  typedef enum logic [1:0] {
    PWR_SLEEP = 2'b00,
    PWR_CHARGE = 2'b01,
    PWR_RUN = 2'b11,
    PWR_SHUTDOWN = 2'b10
  } pwr_state_e;

endpackage

/* File: src/codec_pin_sync.sv */
// Three-stage synchroniser bank with agreement filter for supply detector pins.
// Assumes asynchronous level inputs; output settles when stages two and three agree.
`timescale 1ns/1ps
module codec_pin_sync #(
  parameter int WIDTH = 4
) (
  // Clock and control
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Levels
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);

  initial begin
    if (WIDTH < 1) $error("codec_pin_sync: WIDTH must be positive");
  end

  logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [WIDTH-1:0] s1_nxt, s2_nxt, s3_nxt, lvl_nxt;

  always_comb begin
    s1_nxt = s1_r;
    s2_nxt = s2_r;
    s3_nxt = s3_r;
    lvl_nxt = lvl_r;
    if (clk_en) begin
      s1_nxt = pin_in;
      s2_nxt = s1_r;
      s3_nxt = s2_r;
      // Only a settled level counts; s1 is read by s2 alone
      // Disagreement holds the last level in both directions
      lvl_nxt = (s2_r & s3_r) | (lvl_r & (s2_r | s3_r));
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      lvl_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign level_out = lvl_r;

endmodule

/* File: dv/codec_global_control_regs_assertions.sv */
// Checker for the global control register bank.
// Bound to the bank; sees only its ports, one clock domain.
`timescale 1ns/1ps
module regs_checker #(
  parameter int QCHG_CYC0 = 4,
  parameter int QCHG_CYC1 = 6,
  parameter int QCHG_CYC2 = 8,
  parameter int QCHG_CYC3 = 10
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  // Watched ports
  input wire codec_regs_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire codec_regs_pkg::supply_evt_s det_pins,
  input wire codec_regs_pkg::power_ctl_s pwr_ctl,
  input wire logic digital_regulator_en,
  input wire logic reference_en,
  input wire logic shutdown
);
  // ****
  // Helper state
  // ****
  logic soft_r, soft_nxt;
  logic [7:0] page_r, page_nxt, ra_r, ra_nxt, rp_r, rp_nxt, cnt_r, cnt_nxt;
  int lim;
  always_comb begin
    {soft_nxt, page_nxt, ra_nxt, rp_nxt, cnt_nxt} = {soft_r, page_r, ra_r, rp_r, cnt_r};
    if (srst) begin
      {soft_nxt, page_nxt, ra_nxt, rp_nxt, cnt_nxt} = '0;
    end else if (clk_en) begin
      soft_nxt = !soft_r && req.wr && req.addr == codec_regs_pkg::ADDR_SOFT_RESET
        && req.wdata[0] && page_r == codec_regs_pkg::PAGE_ZERO;
      // Requests in the cycle after a soft reset are refused
      if (soft_r) page_nxt = 8'h00;
      else if (req.wr && req.addr == codec_regs_pkg::ADDR_PAGE_SELECT) page_nxt = req.wdata;
      if (req.rd && !soft_r) begin
        ra_nxt = req.addr;
        rp_nxt = page_r;
      end
      cnt_nxt = pwr_ctl.reference_charging ? cnt_r + 8'h01 : 8'h00;
    end
    case (pwr_ctl.fastcharge_time)
      2'h0: lim = QCHG_CYC0;
      2'h1: lim = QCHG_CYC1;
      2'h2: lim = QCHG_CYC2;
      default: lim = QCHG_CYC3;
    endcase
  end
  always_ff @(posedge core_clk) begin
    {soft_r, page_r, ra_r, rp_r, cnt_r} <= {soft_nxt, page_nxt, ra_nxt, rp_nxt, cnt_nxt};
  end
  // ****
  // Properties
  // ****
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  sequence soft_write_s;
    clk_en && !soft_r && soft_nxt;
  endsequence
  sequence quiet_s;
    pwr_ctl == '0 && !digital_regulator_en && !reference_en && !shutdown;
  endsequence
  a_reset_quiet: assert property ($fell(srst) |-> quiet_s ##0 !rvalid)
    else $error("outputs not idle after reset");
  a_read_answer: assert property (clk_en && req.rd && !soft_r |=> rvalid)
    else $error("read not answered");
  a_rvalid_cause: assert property (rvalid && $past(clk_en) |-> $past(req.rd))
    else $error("read valid without read");
  a_page_readback: assert property (rvalid && ra_r == 8'h00 |-> rdata == rp_r)
    else $error("page select read wrong");
  a_other_page: assert property (rvalid && rp_r != 8'h00 && ra_r != 8'h00 |-> rdata == 8'h00)
    else $error("off-page read not zero");
  a_soft_bit_zero: assert property (rvalid && ra_r == 8'h01 |-> rdata == 8'h00)
    else $error("soft reset bit read nonzero");
  a_soft_clears: assert property (soft_write_s |-> ##3 quiet_s)
    else $error("soft reset left outputs set");
  a_ref_needs_digital_regulator: assert property (reference_en |-> digital_regulator_en)
    else $error("reference without regulator");
  a_charge_length: assert property ($fell(pwr_ctl.reference_charging) && pwr_ctl.awake
    && !shutdown |-> cnt_r >= lim - 1 && cnt_r <= lim + 1)
    else $error("quick-charge length wrong");
endmodule

bind codec_global_control_regs regs_checker #(
  .QCHG_CYC0(QCHG_CYC0), .QCHG_CYC1(QCHG_CYC1), .QCHG_CYC2(QCHG_CYC2), .QCHG_CYC3(QCHG_CYC3)
) u_chk (
  .core_clk(core_clk), .srst(srst), .clk_en(clk_en), .req(req), .rdata(rdata),
  .rvalid(rvalid), .det_pins(det_pins), .pwr_ctl(pwr_ctl), .shutdown(shutdown),
  .digital_regulator_en(digital_regulator_en), .reference_en(reference_en)
);

/* File: dv/host_port_model.sv */
// Host side of the register port: single-byte accesses.
// Assumes one-cycle strobes and rvalid raised at the taking edge.
`timescale 1ns/1ps
module host_port_model (
  // Clock
  input wire logic core_clk,
  // Register port
  output codec_regs_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  initial req = '0;
  // Reserved bits only ever carry their reset value
  function automatic logic [7:0] legal(input logic [7:0] a, input logic [7:0] d);
    case (a)
      8'h01: legal = d & 8'h01;
      8'h02: legal = d & 8'h3F;
      8'h03: legal = d & 8'hC3;
      8'h04: legal = d & 8'h42;
      default: legal = d;
    endcase
  endfunction
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 req = {2'b10, a, legal(a, d)};
    @(posedge core_clk);
    // Released lines show no stale value
    #1 req = {2'b00, ~a, ~d};
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    logic got;
    got = 1'b0;
    d = 'x;
    @(posedge core_clk);
    #1 req = {2'b01, a, 8'h00};
    @(posedge core_clk);
    #1 req = {2'b00, ~a, 8'hFF};
    repeat (4) begin
      if (!got && rvalid === 1'b1) begin
        d = rdata;
        got = 1'b1;
      end
      if (!got) @(posedge core_clk) #1;
    end
  endtask
endmodule

/* File: dv/tb_codec_global_control_regs.sv */
// Self-checking bench for the global control register bank.
// Needs the host model and the bound checker compiled before it.
`timescale 1ns/1ps
module tb_codec_global_control_regs;
  // ****
  // Wiring and clock
  // ****
  localparam int QC [4] = '{4, 6, 8, 10};
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic clk_en = 1'b1;
  logic rvalid, digital_regulator_en, reference_en, shutdown;
  logic [7:0] rdata;
  codec_regs_pkg::reg_req_s req;
  codec_regs_pkg::supply_evt_s det_pins = '0;
  codec_regs_pkg::power_ctl_s pwr_ctl;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  initial forever #10 core_clk = ~core_clk;
  host_port_model u_host (.core_clk(core_clk), .req(req), .rdata(rdata), .rvalid(rvalid));
  codec_global_control_regs #(.QCHG_CYC0(QC[0]), .QCHG_CYC1(QC[1]), .QCHG_CYC2(QC[2]),
    .QCHG_CYC3(QC[3])) u_dut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
    .req(req), .rdata(rdata), .rvalid(rvalid), .det_pins(det_pins), .pwr_ctl(pwr_ctl),
    .digital_regulator_en(digital_regulator_en), .reference_en(reference_en),
    .shutdown(shutdown));
  // ****
  // Shared tasks
  // ****
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      $display("FAIL %0t run hung", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_host.read(a, d);
    chk(d, exp);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_reset();
    for (int a = 0; a < 5; a++) rd_chk(8'(a), 8'h00);
    chk({pwr_ctl, digital_regulator_en, reference_en, shutdown}, 12'h000);
    $display("done reset values");
  endtask
  task automatic t_page();
    u_host.write(8'h02, 8'h36);
    idle(2);
    chk({pwr_ctl.fastcharge_time, pwr_ctl.analog_supply_select, pwr_ctl.io_supply_select,
      pwr_ctl.awake}, 5'b11110);
    u_host.write(8'h00, 8'hFF);
    rd_chk(8'h00, 8'hFF);
    u_host.write(8'h02, 8'h00);
    rd_chk(8'h02, 8'h00);
    u_host.write(8'h00, 8'h00);
    rd_chk(8'h02, 8'h36);
    $display("done page select");
  endtask
  task automatic t_charge();
    int n;
    for (int c = 0; c < 4; c++) begin
      u_host.write(8'h02, 8'h00);
      u_host.write(8'h02, {2'b00, 2'(c), 4'h9});
      n = 0;
      repeat (4) if (pwr_ctl.reference_charging !== 1'b1) idle(1);
      while (pwr_ctl.reference_charging === 1'b1 && n < 30) begin
        n++;
        idle(1);
      end
      chk(16'(n >= QC[c] - 1 && n <= QC[c] + 1), 16'h0001);
      chk({digital_regulator_en, reference_en}, 2'b11);
    end
    u_host.write(8'h02, 8'h01);
    idle(3);
    chk({digital_regulator_en, reference_en}, 2'b10);
    u_host.write(8'h02, 8'h00);
    idle(3);
    chk({pwr_ctl.awake, digital_regulator_en}, 2'b00);
    $display("done quick-charge");
  endtask
  task automatic t_supply();
    det_pins = 4'h8;
    idle(6);
    rd_chk(8'h03, 8'h80);
    det_pins = 4'h4;
    idle(6);
    rd_chk(8'h03, 8'h40);
    det_pins = 4'h0;
    u_host.write(8'h03, 8'hFF);
    idle(6);
    rd_chk(8'h03, 8'h01);
    u_host.write(8'h02, 8'h01);
    idle(20);
    det_pins = 4'h2;
    idle(8);
    chk(shutdown, 1'b1);
    rd_chk(8'h03, 8'h03);
    det_pins = 4'h0;
    idle(8);
    chk({shutdown, digital_regulator_en}, 2'b01);
    u_host.write(8'h03, 8'h00);
    idle(20);
    det_pins = 4'h2;
    idle(8);
    det_pins = 4'h0;
    idle(8);
    chk({shutdown, digital_regulator_en}, 2'b00);
    for (int k = 0; k < 2; k++) begin
      u_host.write(8'h04, k ? 8'h42 : 8'h00);
      u_host.write(8'h02, 8'h00);
      u_host.write(8'h02, 8'h01);
      idle(20);
      det_pins = 4'h1;
      idle(8);
      chk({shutdown, pwr_ctl.ignore_clock_error, pwr_ctl.group_address_enable},
        k ? 3'b011 : 3'b100);
      det_pins = 4'h0;
      idle(8);
    end
    $display("done supply status");
  endtask
  task automatic t_soft();
    u_host.write(8'h00, 8'h07);
    u_host.write(8'h01, 8'h01);
    idle(3);
    rd_chk(8'h00, 8'h07);
    rd_chk(8'h04, 8'h00);
    u_host.write(8'h00, 8'h00);
    rd_chk(8'h04, 8'h42);
    u_host.write(8'h01, 8'h01);
    idle(3);
    for (int a = 0; a < 5; a++) rd_chk(8'(a), 8'h00);
    chk({pwr_ctl, digital_regulator_en, reference_en, shutdown}, 12'h000);
    $display("done soft reset");
  endtask
  task automatic t_freeze();
    clk_en = 1'b0;
    u_host.write(8'h00, 8'h05);
    idle(2);
    clk_en = 1'b1;
    rd_chk(8'h00, 8'h00);
    u_host.write(8'h02, 8'h09);
    u_host.write(8'h00, 8'h05);
    idle(2);
    srst = 1'b1;
    idle(2);
    srst = 1'b0;
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h02, 8'h00);
    chk({pwr_ctl, digital_regulator_en, reference_en, shutdown}, 12'h000);
    $display("done freeze and mid-run reset");
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    #1 srst = 1'b0;
    t_reset();
    t_page();
    t_charge();
    t_supply();
    t_soft();
    t_freeze();
    complete_run();
  end
endmodule
